// file: sim/char_display_instruction_port_assertions.sv
// Port checks of the display instruction port.
`timescale 1ns/1ps
`default_nettype none
module char_display_checker #(
   parameter [16:0] CLEAR_CYCLES = 17'h0_00c8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_select,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic busy_flag,
   input wire logic bus_width_sel,
   input wire logic two_lines,
   input wire logic tall_font,
   input wire logic display_on,
   input wire logic cursor_on,
   input wire logic blink_on,
   input wire logic [6:0] display_offset,
   input wire logic [6:0] cursor_addr
);
   localparam int SHORT = 1520;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic idle_q;
   logic [16:0] run_q;
   wire ins = wr_stb && !busy_flag && bus_width_sel && !reg_select;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idle_q <= 1'b0;
         run_q <= 17'h0;
      end else begin
         idle_q <= idle_q | !busy_flag;
         run_q <= busy_flag ? run_q + 17'h1 : 17'h0;
      end
   end
   property p_len; $fell(busy_flag) && idle_q |-> run_q == SHORT || run_q == CLEAR_CYCLES; endproperty
   a_len: assert property (p_len) else $error("busy time wrong");
   property p_go; wr_stb && !busy_flag && bus_width_sel && (reg_select || wr_data != 8'h00) |=> busy_flag; endproperty
   a_go: assert property (p_go) else $error("busy not raised");
   property p_ref; wr_stb && busy_flag |=> $stable({display_on, cursor_on, blink_on, two_lines, tall_font}); endproperty
   a_ref: assert property (p_ref) else $error("write taken while busy");
   property p_st; rd_stb && !reg_select && bus_width_sel |=> rd_data == {$past(busy_flag), $past(cursor_addr)}; endproperty
   a_st: assert property (p_st) else $error("status word wrong");
   property p_one; rd_data != 8'h00 |-> $past(rd_stb); endproperty
   a_one: assert property (p_one) else $error("read data without read");
   property p_brd; rd_stb && reg_select && busy_flag |=> rd_data == 8'h00; endproperty
   a_brd: assert property (p_brd) else $error("data read taken while busy");
   property p_fs; ins && wr_data[7:5] == 3'b001 |=> {bus_width_sel, two_lines, tall_font} == $past(wr_data[4:2]); endproperty
   a_fs: assert property (p_fs) else $error("function set wrong");
   property p_dc; ins && wr_data[7:3] == 5'b00001 |=> {display_on, cursor_on, blink_on} == $past(wr_data[2:0]); endproperty
   a_dc: assert property (p_dc) else $error("display control wrong");
   property p_dd; ins && wr_data[7] |=> cursor_addr == $past(wr_data[6:0]); endproperty
   a_dd: assert property (p_dd) else $error("display address wrong");
   property p_cg; ins && wr_data[7:6] == 2'b01 |=> cursor_addr[5:0] == $past(wr_data[5:0]); endproperty
   a_cg: assert property (p_cg) else $error("glyph address wrong");
   property p_sh; ins && wr_data[7:3] == 5'b00011 |=> $stable(cursor_addr) && display_offset ==
      ($past(wr_data[2]) ? $past(display_offset) - 7'h1 : $past(display_offset) + 7'h1); endproperty
   a_sh: assert property (p_sh) else $error("display shift wrong");
   property p_hold; wr_stb && reg_select && !busy_flag && bus_width_sel |=> $stable(cursor_addr) [*8]; endproperty
   a_hold: assert property (p_hold) else $error("address stepped early");
   cover property (ins && wr_data[7:3] == 5'b00001);
   cover property ($fell(busy_flag) && idle_q);
   cover property (rd_stb && reg_select && busy_flag);
endmodule // char_display_checker
bind char_display_instruction_port char_display_checker #(.CLEAR_CYCLES(CLEAR_CYCLES)) checker_i (
   .clk, .sys_rst, .reg_select, .wr_data, .wr_stb, .rd_stb, .rd_data, .busy_flag, .bus_width_sel,
   .two_lines, .tall_font, .display_on, .cursor_on, .blink_on, .display_offset, .cursor_addr);
`default_nettype wire

// file: sim/char_display_instruction_port_tb_top.sv
// Self-checking bench of the display instruction port.
`timescale 1ns/1ps
`default_nettype none
module char_display_instruction_port_tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   wire reg_select, wr_stb, rd_stb, busy_flag, bus_width_sel, two_lines, tall_font;
   wire display_on, cursor_on, blink_on;
   wire [7:0] wr_data, rd_data;
   wire [6:0] display_offset, cursor_addr;
   logic [7:0] v;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   initial forever #12.5 clk = ~clk;
   char_display_instruction_port #(.CLEAR_CYCLES(17'h0_00c8)) char_display_instruction_port_i (
      .clk, .sys_rst, .reg_select, .wr_data, .wr_stb, .rd_stb, .rd_data, .busy_flag, .bus_width_sel,
      .two_lines, .tall_font, .display_on, .cursor_on, .blink_on, .display_offset, .cursor_addr);
   host_bus_model host_bus_model_i (.clk, .rd_data, .reg_select, .wr_data, .wr_stb, .rd_stb);
   task automatic check(input string nm, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic op(input logic rs, w, input logic [7:0] d);
      host_bus_model_i.op(rs, w, d, v);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      host_bus_model_i.xfer(1'b0, 1'b0, 8'h00, v);
      check("status", v, 8'h80);
      op(1'b0, 1'b1, 8'h85);
      host_bus_model_i.xfer(1'b0, 1'b0, 8'h00, v);
      check("status_ac", v, 8'h85);
      op(1'b1, 1'b1, 8'ha5);
      check("ac_hold", {1'b0, cursor_addr}, 8'h05);
      host_bus_model_i.ready();
      check("ac_step", {1'b0, cursor_addr}, 8'h06);
      op(1'b0, 1'b1, 8'h85);
      op(1'b1, 1'b0, 8'h00);
      check("ram", v, 8'ha5);
      op(1'b0, 1'b1, 8'h04);
      op(1'b0, 1'b1, 8'h87);
      op(1'b1, 1'b1, 8'h11);
      host_bus_model_i.ready();
      check("ac_dec", {1'b0, cursor_addr}, 8'h06);
      op(1'b0, 1'b1, 8'h01);
      host_bus_model_i.ready();
      check("clr_ac", {1'b0, cursor_addr}, 8'h00);
      op(1'b0, 1'b1, 8'h85);
      op(1'b1, 1'b0, 8'h00);
      check("clr_ram", v, 8'h20);
      host_bus_model_i.ready();
      check("clr_inc", {1'b0, cursor_addr}, 8'h06);
      $display("test ram and clear done");
      for (int i = 0; i < 8; i++) begin
         op(1'b0, 1'b1, 8'h08 + i[7:0]);
         check("disp", {5'h00, display_on, cursor_on, blink_on}, i[7:0]);
      end
      op(1'b0, 1'b1, 8'h08);
      host_bus_model_i.xfer(1'b0, 1'b1, 8'h0f, v);
      host_bus_model_i.xfer(1'b1, 1'b0, 8'h00, v);
      check("busy_rd", v, 8'h00);
      check("busy_wr", {5'h00, display_on, cursor_on, blink_on}, 8'h00);
      op(1'b0, 1'b1, 8'h1c);
      check("dsh_r", {1'b0, display_offset}, 8'h7f);
      op(1'b0, 1'b1, 8'h14);
      check("csh_r", {1'b0, cursor_addr}, 8'h07);
      op(1'b0, 1'b1, 8'h18);
      op(1'b0, 1'b1, 8'h18);
      check("dsh_ac", {1'b0, cursor_addr}, 8'h07);
      op(1'b0, 1'b1, 8'h03);
      host_bus_model_i.ready();
      check("home_off", {1'b0, display_offset}, 8'h00);
      check("home_ac", {1'b0, cursor_addr}, 8'h00);
      op(1'b0, 1'b1, 8'h07);
      op(1'b1, 1'b1, 8'h41);
      check("acc_shift", {1'b0, display_offset}, 8'h01);
      $display("test control and shift done");
      op(1'b0, 1'b1, 8'h43);
      op(1'b1, 1'b1, 8'h5a);
      op(1'b0, 1'b1, 8'h43);
      op(1'b1, 1'b0, 8'h00);
      check("glyph", v, 8'h5a);
      op(1'b0, 1'b1, 8'h83);
      op(1'b1, 1'b0, 8'h00);
      check("dd_kept", v, 8'h20);
      op(1'b0, 1'b1, 8'h3c);
      check("fs_all", {5'h00, bus_width_sel, two_lines, tall_font}, 8'h07);
      op(1'b0, 1'b1, 8'h20);
      check("fs8", {5'h00, bus_width_sel, two_lines, tall_font}, 8'h00);
      host_bus_model_i.four = 1'b1;
      op(1'b0, 1'b1, 8'h28);
      check("fs4", {5'h00, bus_width_sel, two_lines, tall_font}, 8'h02);
      op(1'b0, 1'b1, 8'h0e);
      op(1'b0, 1'b1, 8'h01);
      op(1'b0, 1'b1, 8'h06);
      op(1'b1, 1'b1, 8'h3c);
      op(1'b0, 1'b1, 8'h80);
      op(1'b1, 1'b0, 8'h00);
      check("nib_rd", v, 8'h3c);
      check("nib_disp", {5'h00, display_on, cursor_on, blink_on}, 8'h06);
      $display("test glyph and nibble done");
      stop_test();
   end
endmodule // char_display_instruction_port_tb_top
`default_nettype wire

// file: sim/host_bus_model.sv
// Host bus model: byte or nibble transfers with busy polling.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input wire logic clk,
   input wire logic [7:0] rd_data,
   output logic reg_select = 1'b0,
   output logic [7:0] wr_data = 8'h00,
   output logic wr_stb = 1'b0,
   output logic rd_stb = 1'b0
);
   logic four = 1'b0;
   logic [7:0] hi;
   // One strobe cycle; released lines show the inverse of the last value.
   task automatic acc(input logic rs, w, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      reg_select <= rs;
      wr_data <= d;
      wr_stb <= w;
      rd_stb <= !w;
      @(posedge clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      reg_select <= !rs;
      wr_data <= ~d;
      #1 q = rd_data;
   endtask
   task automatic xfer(input logic rs, w, input logic [7:0] d, output logic [7:0] q);
      if (four) begin
         acc(rs, w, {d[7:4], 4'h0}, hi);
         acc(rs, w, {d[3:0], 4'h0}, q);
         q = {hi[7:4], q[7:4]};
      end else begin
         acc(rs, w, d, q);
      end
   endtask
   task automatic ready();
      logic [7:0] s;
      s = 8'hff;
      while (s[7]) xfer(1'b0, 1'b0, 8'h00, s);
   endtask
   task automatic op(input logic rs, w, input logic [7:0] d, output logic [7:0] q);
      ready();
      xfer(rs, w, d, q);
   endtask
endmodule // host_bus_model
`default_nettype wire

// file: verilog/char_display_instruction_port.v
// Instruction decoder, RAM and busy timing of the character display controller.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "char_display_regs.vh"

module char_display_instruction_port #(
   parameter [16:0] CLEAR_CYCLES = `EXEC_LONG_CYCLES
) (
   input wire clk,
   input wire sys_rst,
   input wire reg_select,
   input wire [7:0] wr_data,
   input wire wr_stb,
   input wire rd_stb,
   output wire [7:0] rd_data,
   output wire busy_flag,
   output wire bus_width_sel,
   output wire two_lines,
   output wire tall_font,
   output wire display_on,
   output wire cursor_on,
   output wire blink_on,
   output wire [6:0] display_offset,
   output wire [6:0] cursor_addr
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants and state.

   localparam [16:0] SHORT_CYCLES = `EXEC_SHORT_CYCLES;
   localparam [16:0] TIMER_ONE = 17'h0_0001;
   localparam [6:0] FILL_LAST = `DD_LAST;

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_EXEC = 3'b010;
   localparam [2:0] ST_FILL = 3'b100;

   reg [2:0] state_q;
   reg busy_q;
   reg [16:0] timer_q;
   reg [6:0] fill_q;
   reg [6:0] ac_q;
   reg glyph_sel_q;
   reg step_pend_q;
   reg inc_q;
   reg shift_on_access_q;
   reg bus8_q;
   reg lines_q;
   reg font_q;
   reg disp_q;
   reg curs_q;
   reg blink_q;
   reg [6:0] offset_q;
   reg nib_phase_q;
   reg [3:0] nib_hold_q;
   reg [7:0] rd_byte_q;
   reg [7:0] rd_data_q;

   reg [7:0] dd_ram [0:`DD_DEPTH-1];
   reg [7:0] cg_ram [0:`CG_DEPTH-1];

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Steps a seven-bit address up or down by one, wrapping.
   function [6:0] step7;
      input [6:0] value;
      input up;
      begin
         if (up) begin
            step7 = value + 7'h01;
         end else begin
            step7 = value - 7'h01;
         end
      end
   endfunction

   wire four_bit = !bus8_q;
   wire idle = !busy_q;
   wire last_nib = !four_bit || nib_phase_q;
   wire [7:0] byte_in = four_bit ? {nib_hold_q, wr_data[7:4]} : wr_data;
   wire wr_ok = wr_stb && idle;
   wire wr_go = wr_ok && last_nib;
   wire wr_data_go = wr_go && reg_select;
   wire wr_inst_go = wr_go && !reg_select;
   wire rd_ok = rd_stb && (!reg_select || idle);
   wire rd_data_go = rd_ok && reg_select && last_nib;
   wire [7:0] ram_word = glyph_sel_q ? cg_ram[ac_q[5:0]] : dd_ram[ac_q];
   wire [7:0] rd_word = reg_select ? ram_word : {busy_q, ac_q};

   ////////////////////////////////////////////////////////////////////////////
   // RAM storage.

   always @(posedge clk) begin
      if (state_q == ST_FILL) begin
         dd_ram[fill_q] <= `SPACE_CODE;
      end else if (wr_data_go && !glyph_sel_q) begin
         dd_ram[ac_q] <= byte_in;
      end
   end

   always @(posedge clk) begin
      if (wr_data_go && glyph_sel_q) begin
         cg_ram[ac_q[5:0]] <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Nibble pairing and read data.

   always @(posedge clk) begin
      if (sys_rst) begin
         nib_phase_q <= 1'b0;
         nib_hold_q <= 4'h0;
      end else if (four_bit && (wr_ok || rd_ok)) begin
         nib_phase_q <= !nib_phase_q;
         if (wr_ok && !nib_phase_q) begin
            nib_hold_q <= wr_data[7:4];
         end
      end else if (!four_bit) begin
         nib_phase_q <= 1'b0;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         rd_data_q <= 8'h00;
         rd_byte_q <= 8'h00;
      end else if (rd_ok) begin
         if (!four_bit) begin
            rd_data_q <= rd_word;
         end else if (!nib_phase_q) begin
            rd_data_q <= {rd_word[7:4], 4'h0};
            rd_byte_q <= rd_word;
         end else begin
            rd_data_q <= {rd_byte_q[3:0], 4'h0};
         end
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction execution and busy timing.

   always @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_FILL;
         busy_q <= 1'b1;
         timer_q <= CLEAR_CYCLES - TIMER_ONE;
         fill_q <= 7'h00;
         ac_q <= `HOME_ADDR;
         glyph_sel_q <= 1'b0;
         step_pend_q <= 1'b0;
         inc_q <= `RST_INC;
         shift_on_access_q <= `RST_SHIFT_ON_ACCESS;
         bus8_q <= `RST_BUS_8BIT;
         lines_q <= `RST_TWO_LINES;
         font_q <= `RST_TALL_FONT;
         disp_q <= `RST_DISPLAY_ON;
         curs_q <= `RST_CURSOR_ON;
         blink_q <= `RST_BLINK_ON;
         offset_q <= 7'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (wr_inst_go) begin
                  state_q <= ST_EXEC;
                  busy_q <= 1'b1;
                  timer_q <= SHORT_CYCLES - TIMER_ONE;
                  step_pend_q <= 1'b0;
                  casez (byte_in)
                     8'b1???????: begin
                        ac_q <= byte_in[6:0];
                        glyph_sel_q <= 1'b0;
                     end
                     8'b01??????: begin
                        ac_q <= {1'b0, byte_in[5:0]};
                        glyph_sel_q <= 1'b1;
                     end
                     8'b001?????: begin
                        bus8_q <= byte_in[`FS_BUS_BIT];
                        lines_q <= byte_in[`FS_LINES_BIT];
                        font_q <= byte_in[`FS_FONT_BIT];
                     end
                     8'b0001????: begin
                        if (byte_in[`SH_DISP_BIT]) begin
                           offset_q <= step7(offset_q, !byte_in[`SH_RIGHT_BIT]);
                        end else begin
                           ac_q <= step7(ac_q, byte_in[`SH_RIGHT_BIT]);
                        end
                     end
                     8'b00001???: begin
                        disp_q <= byte_in[`DC_DISP_BIT];
                        curs_q <= byte_in[`DC_CURS_BIT];
                        blink_q <= byte_in[`DC_BLINK_BIT];
                     end
                     8'b000001??: begin
                        inc_q <= byte_in[`EM_INC_BIT];
                        shift_on_access_q <= byte_in[`EM_SHIFT_BIT];
                     end
                     8'b0000001?: begin
                        timer_q <= CLEAR_CYCLES - TIMER_ONE;
                        ac_q <= `HOME_ADDR;
                        glyph_sel_q <= 1'b0;
                        offset_q <= 7'h00;
                     end
                     8'b00000001: begin
                        state_q <= ST_FILL;
                        timer_q <= CLEAR_CYCLES - TIMER_ONE;
                        fill_q <= 7'h00;
                        ac_q <= `HOME_ADDR;
                        glyph_sel_q <= 1'b0;
                        offset_q <= 7'h00;
                        inc_q <= 1'b1;
                     end
                     default: begin
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                     end
                  endcase
               end else if (wr_data_go) begin
                  state_q <= ST_EXEC;
                  busy_q <= 1'b1;
                  timer_q <= SHORT_CYCLES - TIMER_ONE;
                  step_pend_q <= 1'b1;
                  if (shift_on_access_q && !glyph_sel_q) begin
                     offset_q <= step7(offset_q, inc_q);
                  end
               end else if (rd_data_go) begin
                  state_q <= ST_EXEC;
                  busy_q <= 1'b1;
                  timer_q <= SHORT_CYCLES - TIMER_ONE;
                  step_pend_q <= 1'b1;
               end
            end
            ST_FILL: begin
               timer_q <= timer_q - TIMER_ONE;
               fill_q <= fill_q + 7'h01;
               if (fill_q == FILL_LAST) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (timer_q == 17'h0_0000) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  step_pend_q <= 1'b0;
                  if (step_pend_q) begin
                     ac_q <= step7(ac_q, inc_q);
                  end
               end else begin
                  timer_q <= timer_q - TIMER_ONE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign rd_data = rd_data_q;
   assign busy_flag = busy_q;
   assign bus_width_sel = bus8_q;
   assign two_lines = lines_q;
   assign tall_font = font_q;
   assign display_on = disp_q;
   assign cursor_on = curs_q;
   assign blink_on = blink_q;
   assign display_offset = offset_q;
   assign cursor_addr = ac_q;

endmodule // char_display_instruction_port

`default_nettype wire

// file: verilog/char_display_regs.vh
// Constants, field positions, reset values and timing counts of the display instruction port.
// Function
// - Clear fills display RAM with spaces, address zero.
// - Clear forces entry direction to increment.
// - Return home zeroes address and display shift.
// - Status read returns busy flag and address counter.
// - Data access steps address in the same cycle that busy clears.
// - Glyph address set loads six bits, selects glyph.
// - Display address set loads seven bits, selects display.
// - Data write stores byte at address counter.
// - Data read returns byte at address counter.
// - Function set picks bus width, lines, font.
// - Entry mode set picks direction and access shift.
// - Display control switches display, cursor, blink.
// - Shift moves cursor or display, RAM untouched.
// - Four-bit bus moves upper nibble first on lines 7-4.
// - While busy, no further instruction is accepted.
`ifndef CHAR_DISPLAY_REGS_VH
`define CHAR_DISPLAY_REGS_VH

`define CLK_PERIOD_NS 25
`define EXEC_SHORT_NS 38000
`define EXEC_LONG_NS 1520000
`define EXEC_SHORT_CYCLES 17'h0_05f0
`define EXEC_LONG_CYCLES 17'h0_ed80

`define SPACE_CODE 8'h20
`define HOME_ADDR 7'h00
`define DD_DEPTH 128
`define CG_DEPTH 64
`define DD_LAST 7'h7f

`define FS_BUS_BIT 4
`define FS_LINES_BIT 3
`define FS_FONT_BIT 2
`define EM_INC_BIT 1
`define EM_SHIFT_BIT 0
`define DC_DISP_BIT 2
`define DC_CURS_BIT 1
`define DC_BLINK_BIT 0
`define SH_DISP_BIT 3
`define SH_RIGHT_BIT 2

`define RST_BUS_8BIT 1'b1
`define RST_TWO_LINES 1'b0
`define RST_TALL_FONT 1'b0
`define RST_DISPLAY_ON 1'b0
`define RST_CURSOR_ON 1'b0
`define RST_BLINK_ON 1'b0
`define RST_INC 1'b1
`define RST_SHIFT_ON_ACCESS 1'b0

`endif
